// ---- rtl/spc_consts.svh ----
// Register offsets, field positions, reset values and frame counts of the synthesizer config block.
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SPC_ADDR_W 15
`define SPC_OFS_REF_OUT 15'h003C
`define SPC_OFS_FB_DIV_VP 15'h003D
`define SPC_OFS_FB_DIV_N 15'h003E
`define SPC_OFS_OSC_BIAS 15'h003F
`define SPC_OFS_LANE_PE 15'h0048
`define SPC_RDATA_UNMAPPED 8'h00

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPC_RST_REF_OUT 8'h01
`define SPC_RST_FB_DIV_VP 8'h00
`define SPC_RST_FB_DIV_N 8'h20
`define SPC_RST_OSC_BIAS 8'h4F
`define SPC_RST_LANE_PE 8'h00

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define SPC_REF_EN_BIT 0
`define SPC_V_MSB 1
`define SPC_V_LSB 0
`define SPC_P_MSB 3
`define SPC_P_LSB 2
`define SPC_N_MSB 5
`define SPC_BIAS_MSB 6
`define SPC_PE_MSB 3
`define SPC_PE_W 4
`define SPC_CODE_RSVD 2'h3
`define SPC_N_MIN 6'h01
`define SPC_MAX_LANES 8

// ----------------------------------------------------------------------------
// Serial port frame: one read/write flag, 15 address bits, 8 data bits
// ----------------------------------------------------------------------------
`define SPC_HDR_BITS 5'h10
`define SPC_FRAME_BITS 5'h18

`endif

// ---- rtl/spc_pkg.sv ----
// Types shared by the synthesizer config block and its serial port.
`include "spc_consts.svh"
package spc_pkg;

  // --------------------------------------------------------------------------
  // Register block state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ref_ctrl;
    logic [7:0] fb_vp;
    logic [7:0] fb_n;
    logic [7:0] bias;
    logic [7:0] pe;
    logic [2:0] v_ratio;
    logic [2:0] p_ratio;
    logic [5:0] n_ratio;
    logic [2:0] v_cnt;
    logic [1:0] p_cnt;
    logic [5:0] n_cnt;
    logic sample_tick;
    logic fb_tick;
    logic ref_drive;
  } spc_regs_t;

  // --------------------------------------------------------------------------
  // Serial port state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdi_sync;
    logic [1:0] csn_sync;
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic [22:0] in_sr;
    logic [7:0] out_sr;
    logic is_read;
    logic wr_pulse;
    logic [`SPC_ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
  } spc_spi_t;

endpackage

// ---- rtl/spc_spi_slave.sv ----
// Serial configuration port slave, mode 0, 24-bit frames.
`timescale 1ns/1ps
`include "spc_consts.svh"
module spc_spi_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic [`SPC_ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_en,
  output logic [`SPC_ADDR_W-1:0] wr_addr,
  output logic [7:0] wr_data
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  spc_pkg::spc_spi_t st_q;
  spc_pkg::spc_spi_t st_d;
  logic csn;
  logic sclk;
  logic sdi;
  logic rise;
  logic fall;

  // Only the second synchroniser stage is looked at.
  assign csn = st_q.csn_sync[1];
  assign sclk = st_q.sclk_sync[1];
  assign sdi = st_q.sdi_sync[1];
  assign rise = sclk & ~st_q.sclk_prev;
  assign fall = ~sclk & st_q.sclk_prev;
  assign rd_addr = {st_q.in_sr[13:0], sdi};

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.wr_pulse = 1'b0;
    st_d.sclk_sync = {st_q.sclk_sync[0], spi_sclk};
    st_d.sdi_sync = {st_q.sdi_sync[0], spi_sdi};
    st_d.csn_sync = {st_q.csn_sync[0], spi_cs_n};
    st_d.sclk_prev = sclk;
    if (csn) begin
      st_d.bit_cnt = 5'h00;
      st_d.is_read = 1'b0;
    end else begin
      // Bits beyond the frame are dropped so a long burst cannot corrupt a register.
      if (rise && st_q.bit_cnt != `SPC_FRAME_BITS) begin
        st_d.in_sr = {st_q.in_sr[21:0], sdi};
        st_d.bit_cnt = st_q.bit_cnt + 5'h01;
        if (st_q.bit_cnt == `SPC_HDR_BITS - 5'h01) begin
          st_d.is_read = st_q.in_sr[14];
          st_d.out_sr = rd_data;
        end
        if (st_q.bit_cnt == `SPC_FRAME_BITS - 5'h01 && !st_q.is_read) begin
          st_d.wr_pulse = 1'b1;
          st_d.wr_addr = st_q.in_sr[21:7];
          st_d.wr_data = {st_q.in_sr[6:0], sdi};
        end
      end
      if (fall && st_q.bit_cnt > `SPC_HDR_BITS) begin
        st_d.out_sr = {st_q.out_sr[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '{sclk_sync: 2'h0, sdi_sync: 2'h0, csn_sync: 2'h3, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign spi_sdo = st_q.out_sr[7];
  assign spi_sdo_oe = ~csn & st_q.is_read & (st_q.bit_cnt >= `SPC_HDR_BITS);
  assign wr_en = st_q.wr_pulse;
  assign wr_addr = st_q.wr_addr;
  assign wr_data = st_q.wr_data;

endmodule

// ---- rtl/spc_config_regs.sv ----
// Sampling clock synthesizer configuration registers with feedback divider chain.
`timescale 1ns/1ps
`include "spc_consts.svh"
// Operation
// - The reference output is driven only while its enable bit and the synthesizer enable are 1.
// - Second divider codes 0, 1, 2 divide by 1, 2, 4; code 3 is reserved; change under reset.
// - First divider codes 0, 1, 2 divide by 5, 4, 3; code 3 is reserved; change under reset.
// - The first divider feeds the second, and the second makes the sampling clock.
// - The third divider divides the sampling clock by its 6-bit field, reset value 32.
// - One 4-bit pre-emphasis value drives all serial lanes together.
module spc_config_regs #(
  parameter int NUM_LANES = `SPC_MAX_LANES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic synth_enable,
  input wire logic synth_reset,
  input wire logic vco_tick,
  output logic synth_reference_output_en,
  output logic [2:0] v_div_ratio,
  output logic [2:0] p_div_ratio,
  output logic [5:0] n_div_ratio,
  output logic sample_tick,
  output logic fb_tick,
  output logic [`SPC_BIAS_MSB:0] oscillator_bias,
  output logic [NUM_LANES*`SPC_PE_W-1:0] lane_preemphasis
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (NUM_LANES < 1 || NUM_LANES > `SPC_MAX_LANES) begin : g_bad_lanes
    $error("NUM_LANES must lie between 1 and 8.");
  end

  // --------------------------------------------------------------------------
  // Serial port
  // --------------------------------------------------------------------------
  logic [`SPC_ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [`SPC_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;

  spc_spi_slave spc_spi_slave_i (
    .clk(clk),
    .reset_n(reset_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // --------------------------------------------------------------------------
  // Divider code maps
  // --------------------------------------------------------------------------
  function automatic logic [2:0] v_map(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h5;
    case (code)
      2'h0: r = 3'h5;
      2'h1: r = 3'h4;
      2'h2: r = 3'h3;
      default: r = 3'h5;
    endcase
    return r;
  endfunction

  function automatic logic [2:0] p_map(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h1;
    case (code)
      2'h0: r = 3'h1;
      2'h1: r = 3'h2;
      2'h2: r = 3'h4;
      default: r = 3'h1;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam spc_pkg::spc_regs_t RST = '{
    ref_ctrl: `SPC_RST_REF_OUT,
    fb_vp: `SPC_RST_FB_DIV_VP,
    fb_n: `SPC_RST_FB_DIV_N,
    bias: `SPC_RST_OSC_BIAS,
    pe: `SPC_RST_LANE_PE,
    v_ratio: 3'h5,
    p_ratio: 3'h1,
    n_ratio: 6'(`SPC_RST_FB_DIV_N),
    default: '0
  };

  spc_pkg::spc_regs_t st_q;
  spc_pkg::spc_regs_t st_d;
  logic [1:0] v_code;
  logic [1:0] p_code;
  logic [5:0] n_code;
  logic v_wrap;
  logic p_wrap;
  logic n_wrap;

  assign v_code = st_q.fb_vp[`SPC_V_MSB:`SPC_V_LSB];
  assign p_code = st_q.fb_vp[`SPC_P_MSB:`SPC_P_LSB];
  assign n_code = st_q.fb_n[`SPC_N_MSB:0];
  assign v_wrap = st_q.v_cnt == 3'(st_q.v_ratio - 3'h1);
  assign p_wrap = st_q.p_cnt == 2'(st_q.p_ratio - 3'h1);
  assign n_wrap = st_q.n_cnt == st_q.n_ratio - 6'h01;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_comb begin
    case (rd_addr)
      `SPC_OFS_REF_OUT: rd_data = st_q.ref_ctrl;
      `SPC_OFS_FB_DIV_VP: rd_data = st_q.fb_vp;
      `SPC_OFS_FB_DIV_N: rd_data = st_q.fb_n;
      `SPC_OFS_OSC_BIAS: rd_data = st_q.bias;
      `SPC_OFS_LANE_PE: rd_data = st_q.pe;
      default: rd_data = `SPC_RDATA_UNMAPPED;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sample_tick = 1'b0;
    st_d.fb_tick = 1'b0;
    // Reserved bits are stored as written; software keeps them at reset value.
    if (wr_en) begin
      case (wr_addr)
        `SPC_OFS_REF_OUT: st_d.ref_ctrl = wr_data;
        `SPC_OFS_FB_DIV_VP: st_d.fb_vp = wr_data;
        `SPC_OFS_FB_DIV_N: st_d.fb_n = wr_data;
        `SPC_OFS_OSC_BIAS: st_d.bias = wr_data;
        `SPC_OFS_LANE_PE: st_d.pe = wr_data;
        default: st_d.ref_ctrl = st_q.ref_ctrl;
      endcase
    end
    st_d.ref_drive = st_q.ref_ctrl[`SPC_REF_EN_BIT] & synth_enable;
    if (synth_reset) begin
      // Ratios load only here, so a write while running cannot glitch the loop.
      if (v_code != `SPC_CODE_RSVD) begin
        st_d.v_ratio = v_map(v_code);
      end
      if (p_code != `SPC_CODE_RSVD) begin
        st_d.p_ratio = p_map(p_code);
      end
      if (n_code >= `SPC_N_MIN) begin
        st_d.n_ratio = n_code;
      end
      st_d.v_cnt = 3'h0;
      st_d.p_cnt = 2'h0;
      st_d.n_cnt = 6'h00;
    end else if (vco_tick) begin
      st_d.v_cnt = v_wrap ? 3'h0 : st_q.v_cnt + 3'h1;
      if (v_wrap) begin
        st_d.p_cnt = p_wrap ? 2'h0 : st_q.p_cnt + 2'h1;
        if (p_wrap) begin
          st_d.sample_tick = 1'b1;
          st_d.n_cnt = n_wrap ? 6'h00 : st_q.n_cnt + 6'h01;
          st_d.fb_tick = n_wrap;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= RST;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign synth_reference_output_en = st_q.ref_drive;
  assign v_div_ratio = st_q.v_ratio;
  assign p_div_ratio = st_q.p_ratio;
  assign n_div_ratio = st_q.n_ratio;
  assign sample_tick = st_q.sample_tick;
  assign fb_tick = st_q.fb_tick;
  assign oscillator_bias = st_q.bias[`SPC_BIAS_MSB:0];

  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    assign lane_preemphasis[i*`SPC_PE_W +: `SPC_PE_W] = st_q.pe[`SPC_PE_MSB:0];
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_ref_gate;
    1'b1 |=> synth_reference_output_en == ($past(st_q.ref_ctrl[0]) && $past(synth_enable));
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("Reference output gate wrong.");

  property p_ref_reset;
    $rose(reset_n) |-> st_q.ref_ctrl == `SPC_RST_REF_OUT && st_q.n_ratio == 6'h20;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("Reset values wrong.");

  property p_p_map;
    synth_reset && p_code == 2'h2 |=> p_div_ratio == 3'h4;
  endproperty
  a_p_map: assert property (p_p_map) else $error("Second divider ratio wrong.");

  property p_v_map;
    synth_reset && v_code == 2'h2 |=> v_div_ratio == 3'h3;
  endproperty
  a_v_map: assert property (p_v_map) else $error("First divider ratio wrong.");

  sequence s_last_vco;
    vco_tick && !synth_reset && v_wrap && p_wrap;
  endsequence
  property p_chain;
    sample_tick |-> $past(vco_tick) ##0 $past(st_q.v_cnt) == 3'(v_div_ratio - 3'h1);
  endproperty
  a_chain: assert property (p_chain) else $error("Sampling tick not from divider chain.");

  property p_chain_fire;
    s_last_vco |=> sample_tick;
  endproperty
  a_chain_fire: assert property (p_chain_fire) else $error("Sampling tick missing.");

  property p_fb;
    fb_tick |-> sample_tick && $past(st_q.n_cnt) == n_div_ratio - 6'h01;
  endproperty
  a_fb: assert property (p_fb) else $error("Feedback tick not on N-th sample.");

  property p_n_nonzero;
    n_div_ratio != 6'h00;
  endproperty
  a_n_nonzero: assert property (p_n_nonzero) else $error("Third divider ratio is zero.");

  property p_hold;
    !synth_reset |=> $stable(v_div_ratio) && $stable(p_div_ratio) && $stable(n_div_ratio);
  endproperty
  a_hold: assert property (p_hold) else $error("Divider ratio changed while running.");

  property p_rsvd;
    synth_reset && v_code == `SPC_CODE_RSVD |=> $stable(v_div_ratio);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("Reserved divider code applied.");

  property p_lanes;
    wr_en && wr_addr == `SPC_OFS_LANE_PE |=> lane_preemphasis[`SPC_PE_W-1:0] == $past(wr_data[3:0])
      ##0 lane_preemphasis[NUM_LANES*`SPC_PE_W-1 -: `SPC_PE_W] == $past(wr_data[3:0]);
  endproperty
  a_lanes: assert property (p_lanes) else $error("Lane pre-emphasis not common.");

endmodule

// ---- tb/tb_sampling_pll_config_regs.sv ----
// Self-checking bench for the synthesizer configuration register block.
`timescale 1ns/1ps
`include "spc_consts.svh"
module tb_sampling_pll_config_regs;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] rst;
    logic [7:0] wval;
  } spc_row_t;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic spi_sclk = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sdi = 1'b0;
  logic synth_enable = 1'b1;
  logic synth_reset = 1'b1;
  logic vco_tick = 1'b0;
  logic counting = 1'b0;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic ref_en;
  logic smp_tick;
  logic fbk_tick;
  logic [2:0] v_ratio;
  logic [2:0] p_ratio;
  logic [5:0] n_ratio;
  logic [6:0] bias;
  logic [31:0] pe_lanes;
  logic [7:0] rd;
  int num_errors = 0;
  int num_checks = 0;
  int smp_cnt = 0;
  int fb_cnt = 0;
  // Reserved fields keep their reset value in every write value below.
  spc_row_t rows [5] = '{
    '{`SPC_OFS_REF_OUT, 8'h01, 8'h00},
    '{`SPC_OFS_FB_DIV_VP, 8'h00, 8'h06},
    '{`SPC_OFS_FB_DIV_N, 8'h20, 8'h03},
    '{`SPC_OFS_OSC_BIAS, 8'h4F, 8'h4A},
    '{`SPC_OFS_LANE_PE, 8'h00, 8'h0A}};
  logic [2:0] v_exp [4] = '{3'h5, 3'h4, 3'h3, 3'h3};
  logic [2:0] p_exp [4] = '{3'h1, 3'h2, 3'h4, 3'h4};

  spc_config_regs #(.NUM_LANES(8)) spc_config_regs_i (
    .clk(clk),
    .reset_n(reset_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .synth_enable(synth_enable),
    .synth_reset(synth_reset),
    .vco_tick(vco_tick),
    .synth_reference_output_en(ref_en),
    .v_div_ratio(v_ratio),
    .p_div_ratio(p_ratio),
    .n_div_ratio(n_ratio),
    .sample_tick(smp_tick),
    .fb_tick(fbk_tick),
    .oscillator_bias(bias),
    .lane_preemphasis(pe_lanes)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (counting) begin
      if (smp_tick === 1'b1) smp_cnt++;
      if (fbk_tick === 1'b1) fb_cnt++;
    end
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each serial clock level lasts 5 cycles, three more than the two-stage synchronizer needs.
  task automatic spi_xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wd);
    logic [23:0] fr;
    fr = {rw, addr, wd};
    spi_cs_n = 1'b0;
    tick(5);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = fr[i];
      tick(5);
      if (i < 8) rd[i] = spi_sdo;
      if (i == 0) chk_port({31'h0, spi_sdo_oe}, {31'h0, rw});
      spi_sclk = 1'b1;
      tick(5);
      spi_sclk = 1'b0;
    end
    tick(5);
    spi_cs_n = 1'b1;
    tick(8);
  endtask

  task automatic wr(input logic [14:0] addr, input logic [7:0] wd);
    spi_xfer(1'b0, addr, wd);
  endtask

  task automatic rdchk(input logic [14:0] addr, input logic [7:0] exp);
    spi_xfer(1'b1, addr, 8'h00);
    chk_reg(rd, exp);
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    tick(12);
    reset_n = 1'b1;
    tick(3);
    chk_port({31'h0, ref_en}, 32'h1);
    chk_port({25'h0, bias}, 32'h4F);
    chk_port(pe_lanes, 32'h0);
    chk_port({29'h0, v_ratio}, 32'h5);
    chk_port({29'h0, p_ratio}, 32'h1);
    chk_port({26'h0, n_ratio}, 32'h20);
    for (int r = 0; r < 5; r++) begin
      rdchk(rows[r].addr, rows[r].rst);
    end
    rdchk(15'h0100, `SPC_RDATA_UNMAPPED);
    synth_reset = 1'b0;
    for (int r = 0; r < 5; r++) begin
      wr(rows[r].addr, rows[r].wval);
      rdchk(rows[r].addr, rows[r].wval);
    end
    chk_port({25'h0, bias}, 32'h4A);
    chk_port(pe_lanes, 32'hAAAAAAAA);
    chk_port({31'h0, ref_en}, 32'h0);
    chk_port({29'h0, v_ratio}, 32'h5);
    chk_port({26'h0, n_ratio}, 32'h20);
    synth_reset = 1'b1;
    tick(2);
    chk_port({29'h0, v_ratio}, 32'h3);
    chk_port({29'h0, p_ratio}, 32'h2);
    chk_port({26'h0, n_ratio}, 32'h3);
    synth_reset = 1'b0;
    tick(1);
    // Ratio 3 * 2 gives a sample every 6 oscillator ticks, feedback every 18.
    counting = 1'b1;
    vco_tick = 1'b1;
    tick(72);
    vco_tick = 1'b0;
    tick(3);
    counting = 1'b0;
    chk_port(smp_cnt, 32'hC);
    chk_port(fb_cnt, 32'h4);
    wr(`SPC_OFS_REF_OUT, 8'h01);
    for (int e = 0; e < 2; e++) begin
      synth_enable = e[0];
      tick(2);
      chk_port({31'h0, ref_en}, {31'h0, e[0]});
    end
    for (int c = 0; c < 4; c++) begin
      synth_reset = 1'b1;
      wr(`SPC_OFS_FB_DIV_VP, {4'h0, c[1:0], c[1:0]});
      tick(2);
      synth_reset = 1'b0;
      chk_port({29'h0, v_ratio}, {29'h0, v_exp[c]});
      chk_port({29'h0, p_ratio}, {29'h0, p_exp[c]});
    end
    synth_reset = 1'b1;
    wr(`SPC_OFS_FB_DIV_N, 8'h3F);
    tick(2);
    chk_port({26'h0, n_ratio}, 32'h3F);
    wr(`SPC_OFS_FB_DIV_N, 8'h00);
    tick(2);
    chk_port({26'h0, n_ratio}, 32'h3F);
    end_of_test;
  end

  // The whole sequence needs about 6000 cycles; the limit leaves ample margin.
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
endmodule
